// ==== bench/btc_counter_tb_top.sv ====
// Self-checking bench for the buffered timebase counter
module btc_counter_tb_top;
  import btc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk_i;
  logic             rst_i;
  logic             cyc_i;
  logic             stb_i;
  logic             we_i;
  logic [ADR_W-1:0] adr_i;
  logic [3:0]       sel_i;
  logic [31:0]      dat_i;
  logic [31:0]      dat_o;
  logic             ack_o;
  logic             event_i;
  logic [CNT_W-1:0] tally_o;
  logic             top_o;
  logic             bottom_o;
  logic             max_o;
  logic             update_o;
  logic [N_MATCH-1:0] match_o;
  logic [31:0]      rd;
  int               fails;
  int               check_count;
  int               n;
  bit               seen;

  btc_counter uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .event_i(event_i), .tally_o(tally_o), .top_o(top_o), .bottom_o(bottom_o),
    .max_o(max_o), .update_o(update_o), .match_o(match_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Verdict and checks
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // ==========================================================
  // Classic Wishbone single cycles; wait for ack, bounded
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
    int k;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      $display("[FAIL] %0t bus timeout", $time);
      finish_test();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Waits for a pulse: 0 top, 1 bottom, 2 max, 3 update, 4 to 6 match0 to match2
  task automatic wait_pulse(input int idx, input int lim);
    int         k;
    logic [6:0] ind;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
      ind = {match_o, update_o, max_o, bottom_o, top_o};
    end while (ind[idx] !== 1'b1 && k < lim);
    if (k >= lim) begin
      fails++;
      $display("[FAIL] %0t indication %0d never pulsed", $time, idx);
      finish_test();
    end
  endtask : wait_pulse

  task automatic event_pulse;
    event_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    event_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : event_pulse

  // ==========================================================
  // Main sequence
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = '0;
    sel_i = '0;
    dat_i = '0;
    event_i = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);

    wb(1'b0, ADR_CYCLE, '0);     check(rd, 32'h0000ffff, "cycle reset");
    wb(1'b0, ADR_CYCLE_BUF, '0); check(rd, 32'h0000ffff, "buffer reset");
    wb(1'b0, ADR_CTRL_F, '0);    check(rd, 32'h0, "flags reset");
    wb(1'b0, 8'hfc, '0);         check(rd, 32'h0, "unmapped read");
    $display("Test reset values done");

    // Holds with no enable; up count wraps after upper limit
    repeat (10) @(posedge clk_i);
    check(tally_o, 16'h0000, "held while disabled");
    wb(1'b1, ADR_CYCLE, 32'h5);
    wb(1'b1, ADR_CTRL_A, 32'h1);
    wait_pulse(0, 20); check(tally_o, 16'h0000, "wrap to zero");
    $display("Test up wrap done");

    // Buffered cycle length moves only at the update condition
    wb(1'b1, ADR_CTRL_A, 32'h0);
    wb(1'b1, ADR_CYCLE_BUF, 32'h3);
    wb(1'b0, ADR_CTRL_F, '0);    check(rd, 32'h1, "cycle flag set");
    wb(1'b0, ADR_CYCLE, '0);     check(rd, 32'h5, "active kept");
    wb(1'b1, ADR_CTRL_A, 32'h1);
    wait_pulse(3, 20);
    wb(1'b0, ADR_CYCLE, '0);     check(rd, 32'h3, "cycle moved");
    wb(1'b0, ADR_CTRL_F, '0);    check(rd, 32'h0, "cycle flag clear");
    $display("Test cycle buffer done");

    // Updates held: flag stays set and active match keeps its value until released
    wb(1'b1, ADR_CTRL_A, 32'h0);
    wb(1'b1, ADR_CTRL_E, 32'h2);
    wb(1'b1, ADR_MATCH_BUF, 32'h2);
    wb(1'b1, ADR_CTRL_A, 32'h1);
    wait_pulse(1, 20);
    wait_pulse(1, 20);
    wb(1'b1, ADR_CTRL_A, 32'h0);
    wb(1'b0, ADR_CTRL_F, '0);    check(rd, 32'h2, "match flag held");
    wb(1'b0, ADR_MATCH, '0);     check(rd, 32'h0, "match held");
    wb(1'b1, ADR_CTRL_E, 32'h0);
    wb(1'b1, ADR_CTRL_A, 32'h1);
    wait_pulse(3, 20);
    wb(1'b0, ADR_MATCH, '0);     check(rd, 32'h2, "match moved");
    $display("Test update hold done");

    // Match indication one clock after the tick at the match value
    wait_pulse(4, 20); check(tally_o, 16'h0003, "match timing");
    wb(1'b1, ADR_MATCH + ADR_STRIDE, 32'h1);
    wb(1'b0, ADR_MATCH + ADR_STRIDE, '0); check(rd, 32'h1, "direct match");
    wait_pulse(5, 20); check(tally_o, 16'h0002, "match1 timing");
    wait_pulse(6, 20); check(tally_o, 16'h0001, "match2 timing");
    $display("Test match done");

    // Tally write, direct cycle length, count down with reload
    wb(1'b1, ADR_CTRL_A, 32'h0);
    wb(1'b1, ADR_TALLY, 32'h2);
    wb(1'b0, ADR_TALLY, '0);     check(rd, 32'h2, "tally written");
    wb(1'b1, ADR_CYCLE, 32'h4);
    wb(1'b1, ADR_CTRL_A, 32'h1);
    wb(1'b1, ADR_CTRL_E, 32'h1);
    wait_pulse(1, 20); check(tally_o, 16'h0004, "down reload");
    $display("Test down count done");

    // Update at the upper limit instead of at zero
    wb(1'b1, ADR_CTRL_E, 32'h4);
    wb(1'b1, ADR_CYCLE_BUF, 32'h6);
    wait_pulse(3, 20); check(tally_o, 16'h0000, "update at top");
    wb(1'b0, ADR_CYCLE, '0);     check(rd, 32'h6, "top update moved");
    $display("Test update at top done");

    // Prescaler: choice 2 gives one tick every four clocks
    wb(1'b1, ADR_CTRL_A, 32'h0);
    wb(1'b1, ADR_CTRL_E, 32'h0);
    wb(1'b1, ADR_CYCLE, 32'hffff);
    wb(1'b1, ADR_CTRL_A, 32'h5);
    rd = {16'h0, tally_o};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tally_o === rd[15:0] && n < 20);
    check(n < 20, 1'b1, "prescale first tick");
    rd = {16'h0, tally_o};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tally_o === rd[15:0] && n < 20);
    check(n, 32'd4, "prescale spacing");
    $display("Test prescale done");

    // Counting on events instead of clock ticks
    wb(1'b1, ADR_CTRL_A, 32'h0);
    wb(1'b1, ADR_TALLY, 32'h0);
    wb(1'b1, ADR_EVENT, 32'h1);
    wb(1'b1, ADR_CTRL_A, 32'h1);
    repeat (3) event_pulse();
    wb(1'b0, ADR_TALLY, '0);     check(rd, 32'h3, "event count");
    $display("Test events done");

    // Cycle length cut below count: runs through all ones and wraps
    wb(1'b1, ADR_CTRL_A, 32'h0);
    wb(1'b1, ADR_EVENT, 32'h0);
    wb(1'b1, ADR_TALLY, 32'h20);
    wb(1'b1, ADR_CYCLE, 32'h10);
    wb(1'b1, ADR_CTRL_A, 32'h1);
    seen = 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (top_o === 1'b1) seen = 1'b1;
    end while (max_o !== 1'b1 && n < 70000);
    check(max_o, 1'b1, "max reached");
    check(tally_o, 16'h0000, "wrap at all ones");
    check(seen, 1'b0, "no early limit");
    $display("Test cut period done");

    finish_test();
  end
endmodule : btc_counter_tb_top

// ==== include/btc_pkg.sv ====
// Package for the buffered timebase counter: register map, fields and state
package btc_pkg;

  localparam int unsigned CNT_W   = 16;
  localparam int unsigned N_MATCH = 3;
  localparam int unsigned PRE_W   = 8;
  localparam int unsigned ADR_W   = 8;
  localparam int unsigned SEL_W   = 3;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADR_W-1:0] ADR_CTRL_A   = 8'h00;
  localparam logic [ADR_W-1:0] ADR_CTRL_E   = 8'h04;
  localparam logic [ADR_W-1:0] ADR_CTRL_F   = 8'h08;
  localparam logic [ADR_W-1:0] ADR_EVENT    = 8'h0c;
  localparam logic [ADR_W-1:0] ADR_TALLY    = 8'h10;
  localparam logic [ADR_W-1:0] ADR_CYCLE    = 8'h14;
  localparam logic [ADR_W-1:0] ADR_CYCLE_BUF = 8'h18;
  localparam logic [ADR_W-1:0] ADR_MATCH    = 8'h20;
  localparam logic [ADR_W-1:0] ADR_MATCH_BUF = 8'h30;
  localparam logic [ADR_W-1:0] ADR_STRIDE   = 8'h04;

  // ==========================================================
  // Field positions
  localparam int unsigned A_ENABLE   = 0;
  localparam int unsigned A_PSEL_LO  = 1;
  localparam int unsigned E_DOWN     = 0;
  localparam int unsigned E_HOLD     = 1;
  localparam int unsigned E_UPD_TOP  = 2;
  localparam int unsigned F_CYCLE_BV = 0;
  localparam int unsigned F_MATCH_BV = 1;
  localparam int unsigned EV_COUNT   = 0;

  // ==========================================================
  // Reset values and count constants
  localparam logic [CNT_W-1:0] CNT_RST   = 16'h0000;
  localparam logic [CNT_W-1:0] CYCLE_RST = 16'hffff;
  localparam logic [CNT_W-1:0] MATCH_RST = 16'h0000;
  localparam logic [CNT_W-1:0] BOTTOM    = 16'h0000;
  localparam logic [CNT_W-1:0] ONE       = 16'h0001;
  localparam logic [CNT_W-1:0] ALL_ONES  = 16'hffff;

  typedef enum logic [0:0] {
    BTC_IDLE = 1'b0,
    BTC_ACK  = 1'b1
  } btc_bus_type;

  typedef struct packed {
    logic                          enable;
    logic [SEL_W-1:0]              prescale_choice;
    logic                          up_down_select;
    logic                          hold_updates;
    logic                          update_at_top;
    logic                          event_count_enable;
    logic [CNT_W-1:0]              tally_value;
    logic [CNT_W-1:0]              cycle_length_value;
    logic [CNT_W-1:0]              cycle_length_buffer;
    logic                          cycle_length_buffer_valid;
    logic [N_MATCH-1:0][CNT_W-1:0] match_value;
    logic [N_MATCH-1:0][CNT_W-1:0] match_buffer;
    logic [N_MATCH-1:0]            match_buffer_valid;
    logic [PRE_W-1:0]              prescale_cnt;
    logic [2:0]                    event_sync;
    btc_bus_type                   bus;
    logic [31:0]                   rd_data;
    logic                          top_hit;
    logic                          bottom_hit;
    logic                          max_hit;
    logic                          update_hit;
    logic [N_MATCH-1:0]            match_hit;
  } btc_state_type;

endpackage : btc_pkg

// ==== rtl/btc_counter.sv ====
// Buffered timebase counter with classic Wishbone register slave
// ==========================================================
// How it works
// - Count value zero means the lowest limit is reached.
// - Count value all ones means maximum is reached.
// - Count equal to active cycle length means upper limit reached.
// - Update at lowest or upper limit copies valid buffers unless held.
// - Writing enable one starts counting at the prescale_choice rate.
// - With event_count_enable set, incoming events advance the counter.
// - up_down_select in control_reg_e picks counting direction.
// - Ticks come from the peripheral clock divided per prescale_choice.
// - Counting up past the upper limit wraps to zero on next tick.
// - Counting down at zero reloads the active cycle length.
// - Software tally write is immediate and beats count, clear, reload.
// - Direction change while running takes effect on next tick.
// - Cycle length and each match have buffers with valid flags.
// - Buffer write sets its valid flag; a transfer clears it.
// - Active match registers are directly writable, bypassing buffers.
// - Direct cycle length write applies at once.
// - Cycle length cut below count: counter runs on and wraps.
// - Buffered cycle length changes the active one only at update.
// - Counter, cycle length, matches and buffers are sixteen bits.
// - Limit and match indications appear one clock after the tick.
module btc_counter
  import btc_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [ADR_W-1:0]          adr_i,
  input  wire logic [3:0]                sel_i,
  input  wire logic [31:0]               dat_i,
  output logic      [31:0]               dat_o,
  output logic                           ack_o,
  input  wire logic                      event_i,
  output logic      [CNT_W-1:0]          tally_o,
  output logic                           top_o,
  output logic                           bottom_o,
  output logic                           max_o,
  output logic                           update_o,
  output logic      [N_MATCH-1:0]        match_o
);

  btc_state_type s_q;
  btc_state_type s_d;

  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] lane_write(input logic [CNT_W-1:0] old,
                                                  input logic [31:0]      data,
                                                  input logic [3:0]       sel);
    lane_write = old;
    if (sel[0]) begin
      lane_write[7:0] = data[7:0];
    end
    if (sel[1]) begin
      lane_write[15:8] = data[15:8];
    end
  endfunction : lane_write

  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] base,
                               input int unsigned idx);
    hit = (adr == base + ADR_W'(idx) * ADR_STRIDE);
  endfunction : hit

  logic                  req;
  logic                  wr;
  logic                  tick;
  logic                  pre_tick;
  logic                  event_edge;
  logic                  at_top;
  logic                  at_bottom;
  logic                  do_update;
  logic [PRE_W-1:0]      pre_mask;
  logic [CNT_W-1:0]      next_cnt;
  logic [31:0]           rd_mux;

  // ==========================================================
  // Tick and limit detection
  always_comb begin
    req        = cyc_i & stb_i;
    wr         = req & we_i & (s_q.bus == BTC_ACK);
    pre_mask   = PRE_W'((9'h001 << s_q.prescale_choice) - 9'h001);
    pre_tick   = (s_q.prescale_cnt & pre_mask) == pre_mask;
    event_edge = s_q.event_sync[1] & ~s_q.event_sync[2];
    tick       = s_q.enable & (s_q.event_count_enable ? event_edge
                                                      : pre_tick);
    at_bottom  = s_q.tally_value == BOTTOM;
    at_top     = s_q.tally_value == s_q.cycle_length_value;
    do_update  = tick & (s_q.update_at_top ? at_top : at_bottom);
    if (!s_q.up_down_select) begin
      next_cnt = at_top ? BOTTOM : s_q.tally_value + ONE;
    end else begin
      next_cnt = at_bottom ? s_q.cycle_length_value
                           : s_q.tally_value - ONE;
    end
  end

  // ==========================================================
  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (adr_i == ADR_CTRL_A) begin
      rd_mux[A_ENABLE]                          = s_q.enable;
      rd_mux[A_PSEL_LO +: SEL_W]                = s_q.prescale_choice;
    end
    if (adr_i == ADR_CTRL_E) begin
      rd_mux[E_DOWN]    = s_q.up_down_select;
      rd_mux[E_HOLD]    = s_q.hold_updates;
      rd_mux[E_UPD_TOP] = s_q.update_at_top;
    end
    if (adr_i == ADR_CTRL_F) begin
      rd_mux[F_CYCLE_BV]               = s_q.cycle_length_buffer_valid;
      rd_mux[F_MATCH_BV +: N_MATCH]    = s_q.match_buffer_valid;
    end
    if (adr_i == ADR_EVENT) begin
      rd_mux[EV_COUNT] = s_q.event_count_enable;
    end
    if (adr_i == ADR_TALLY) begin
      rd_mux[CNT_W-1:0] = s_q.tally_value;
    end
    if (adr_i == ADR_CYCLE) begin
      rd_mux[CNT_W-1:0] = s_q.cycle_length_value;
    end
    if (adr_i == ADR_CYCLE_BUF) begin
      rd_mux[CNT_W-1:0] = s_q.cycle_length_buffer;
    end
    for (int i = 0; i < N_MATCH; i++) begin
      if (hit(adr_i, ADR_MATCH, i)) begin
        rd_mux[CNT_W-1:0] = s_q.match_value[i];
      end
      if (hit(adr_i, ADR_MATCH_BUF, i)) begin
        rd_mux[CNT_W-1:0] = s_q.match_buffer[i];
      end
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d            = s_q;
    s_d.event_sync = {s_q.event_sync[1:0], event_i};
    s_d.prescale_cnt = s_q.enable ? s_q.prescale_cnt + PRE_W'(1) : '0;

    // Bus: answer one cycle after the request, write at the ack edge
    s_d.bus = (req && s_q.bus == BTC_IDLE) ? BTC_ACK : BTC_IDLE;
    if (req && s_q.bus == BTC_IDLE) begin
      s_d.rd_data = rd_mux;
    end

    // Counting; a tally write below overrides it
    if (tick) begin
      s_d.tally_value = next_cnt;
    end

    // Transfer happens before buffer writes so a same-cycle write re-arms the flag
    if (do_update && !s_q.hold_updates) begin
      if (s_q.cycle_length_buffer_valid) begin
        s_d.cycle_length_value        = s_q.cycle_length_buffer;
        s_d.cycle_length_buffer_valid = 1'b0;
      end
      for (int i = 0; i < N_MATCH; i++) begin
        if (s_q.match_buffer_valid[i]) begin
          s_d.match_value[i]        = s_q.match_buffer[i];
          s_d.match_buffer_valid[i] = 1'b0;
        end
      end
    end

    if (wr) begin
      if (adr_i == ADR_CTRL_A && sel_i[0]) begin
        s_d.enable          = dat_i[A_ENABLE];
        s_d.prescale_choice = dat_i[A_PSEL_LO +: SEL_W];
      end
      if (adr_i == ADR_CTRL_E && sel_i[0]) begin
        s_d.up_down_select = dat_i[E_DOWN];
        s_d.hold_updates   = dat_i[E_HOLD];
        s_d.update_at_top  = dat_i[E_UPD_TOP];
      end
      if (adr_i == ADR_EVENT && sel_i[0]) begin
        s_d.event_count_enable = dat_i[EV_COUNT];
      end
      if (adr_i == ADR_TALLY) begin
        s_d.tally_value = lane_write(s_q.tally_value, dat_i, sel_i);
      end
      if (adr_i == ADR_CYCLE) begin
        s_d.cycle_length_value = lane_write(s_q.cycle_length_value,
                                            dat_i, sel_i);
      end
      if (adr_i == ADR_CYCLE_BUF) begin
        s_d.cycle_length_buffer       = lane_write(s_q.cycle_length_buffer, dat_i, sel_i);
        s_d.cycle_length_buffer_valid = 1'b1;
      end
      for (int i = 0; i < N_MATCH; i++) begin
        if (hit(adr_i, ADR_MATCH, i)) begin
          s_d.match_value[i] = lane_write(s_q.match_value[i], dat_i, sel_i);
        end
        if (hit(adr_i, ADR_MATCH_BUF, i)) begin
          s_d.match_buffer[i]       = lane_write(s_q.match_buffer[i], dat_i, sel_i);
          s_d.match_buffer_valid[i] = 1'b1;
        end
      end
    end

    // Indications one clock after the triggering tick
    s_d.top_hit    = tick & at_top;
    s_d.bottom_hit = tick & at_bottom;
    s_d.max_hit    = tick & (s_q.tally_value == ALL_ONES);
    s_d.update_hit = do_update;
    for (int i = 0; i < N_MATCH; i++) begin
      s_d.match_hit[i] = tick & (s_q.tally_value == s_q.match_value[i]);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q                     <= '0;
      s_q.bus                 <= BTC_IDLE;
      s_q.tally_value         <= CNT_RST;
      s_q.cycle_length_value  <= CYCLE_RST;
      s_q.cycle_length_buffer <= CYCLE_RST;
      for (int i = 0; i < N_MATCH; i++) begin
        s_q.match_value[i]  <= MATCH_RST;
        s_q.match_buffer[i] <= MATCH_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign dat_o    = s_q.rd_data;
  assign ack_o    = (s_q.bus == BTC_ACK);
  assign tally_o  = s_q.tally_value;
  assign top_o    = s_q.top_hit;
  assign bottom_o = s_q.bottom_hit;
  assign max_o    = s_q.max_hit;
  assign update_o = s_q.update_hit;
  assign match_o  = s_q.match_hit;

  // ==========================================================
  // Checks
  logic tally_wr;
  assign tally_wr = wr & (adr_i == ADR_TALLY);

  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_up_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && !s_q.up_down_select && !at_top && !tally_wr
      |=> tally_o == $past(tally_o) + ONE)
    else $error("up count did not advance by one");

  a_up_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && !s_q.up_down_select && at_top && !tally_wr |=> tally_o == BOTTOM)
    else $error("no wrap to zero at upper limit");

  a_down_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && s_q.up_down_select && at_bottom && !tally_wr
      |=> tally_o == $past(s_q.cycle_length_value))
    else $error("no reload at zero when counting down");

  a_tally_write_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    tally_wr && sel_i == 4'hf |=> tally_o == $past(dat_i[CNT_W-1:0]))
    else $error("tally write lost");

  a_disabled_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.enable && !tally_wr |=> tally_o == $past(tally_o))
    else $error("count moved while disabled");

  a_hold_keeps_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.hold_updates && s_q.cycle_length_buffer_valid |=> s_q.cycle_length_buffer_valid)
    else $error("valid flag cleared while updates held");

  a_update_transfer: assert property (@(posedge clk_i) disable iff (rst_i)
    do_update && !s_q.hold_updates && s_q.cycle_length_buffer_valid
      && !(wr && (adr_i == ADR_CYCLE || adr_i == ADR_CYCLE_BUF))
      |=> !s_q.cycle_length_buffer_valid
          && s_q.cycle_length_value == $past(s_q.cycle_length_buffer))
    else $error("buffered cycle length not transferred");

  a_top_indication: assert property (@(posedge clk_i) disable iff (rst_i)
    top_o == $past(tick && at_top))
    else $error("upper limit indication not one clock after tick");

  // ==========================================================
  // Indications follow the tick that caused them by one clock
  a_bottom_indication: assert property (@(posedge clk_i) disable iff (rst_i)
    bottom_o == $past(tick && tally_o == BOTTOM))
    else $error("lowest limit indication wrong");

  a_max_indication: assert property (@(posedge clk_i) disable iff (rst_i)
    max_o == $past(tick && tally_o == ALL_ONES))
    else $error("maximum indication wrong");

  a_match_indication: assert property (@(posedge clk_i) disable iff (rst_i)
    match_o[0] == $past(tick && tally_o == s_q.match_value[0]))
    else $error("match indication wrong");

  a_update_indication: assert property (@(posedge clk_i) disable iff (rst_i)
    update_o == $past(do_update))
    else $error("update indication wrong");

  a_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.enable |=> !top_o && !bottom_o && !max_o && !update_o && match_o == '0)
    else $error("indication while disabled");

  // ==========================================================
  // Counting
  a_down_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && s_q.up_down_select && !at_bottom && !tally_wr
      |=> tally_o == $past(tally_o) - ONE)
    else $error("down count did not step by one");

  a_max_wraps_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && !s_q.up_down_select && !at_top && tally_o == ALL_ONES && !tally_wr
      |=> tally_o == BOTTOM)
    else $error("no wrap after all ones");

  a_event_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.enable && s_q.event_count_enable && !event_edge && !tally_wr
      |=> tally_o == $past(tally_o))
    else $error("count moved without an event");

  a_prescale_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.enable && !s_q.event_count_enable && !pre_tick && !tally_wr
      |=> tally_o == $past(tally_o))
    else $error("count moved without a prescaler tick");

  // ==========================================================
  // Buffers and direct writes
  a_cycle_buf_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == ADR_CYCLE_BUF |=> s_q.cycle_length_buffer_valid)
    else $error("cycle buffer write left flag clear");

  a_match_buf_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == ADR_MATCH_BUF |=> s_q.match_buffer_valid[0])
    else $error("match buffer write left flag clear");

  a_direct_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == ADR_CYCLE && sel_i == 4'hf
      |=> s_q.cycle_length_value == $past(dat_i[CNT_W-1:0]))
    else $error("direct cycle length write lost");

  a_direct_match: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == ADR_MATCH && sel_i == 4'hf
      |=> s_q.match_value[0] == $past(dat_i[CNT_W-1:0]))
    else $error("direct match write lost");

  a_cycle_only_update: assert property (@(posedge clk_i) disable iff (rst_i)
    !(do_update && !s_q.hold_updates) && !(wr && adr_i == ADR_CYCLE)
      |=> s_q.cycle_length_value == $past(s_q.cycle_length_value))
    else $error("cycle length changed outside update");

  a_match_transfer: assert property (@(posedge clk_i) disable iff (rst_i)
    do_update && !s_q.hold_updates && s_q.match_buffer_valid[0]
      && !(wr && (adr_i == ADR_MATCH || adr_i == ADR_MATCH_BUF))
      |=> !s_q.match_buffer_valid[0] && s_q.match_value[0] == $past(s_q.match_buffer[0]))
    else $error("buffered match not transferred");

  a_hold_keeps_match: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.hold_updates && s_q.match_buffer_valid[0] && !(wr && adr_i == ADR_MATCH_BUF)
      |=> s_q.match_buffer_valid[0] && s_q.match_buffer[0] == $past(s_q.match_buffer[0]))
    else $error("match buffer lost while updates held");

  // ==========================================================
  // Bus answer
  a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");

  a_read_data_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !(req && !ack_o) |=> $stable(dat_o))
    else $error("read data changed without request");

endmodule : btc_counter
